// file: core/scsup_clkmon.sv
`timescale 1ns/100ps
`default_nettype none
module scsup_clkmon
   import scsup_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   scsup_mon_if.mon mif
);
   logic [1:0] p_sync_ff;
   logic [1:0] a_sync_ff;
   logic p_last_ff;
   logic a_last_ff;
   logic [CW-1:0] p_idle_ff;
   logic [CW-1:0] a_idle_ff;
   logic [CW-1:0] win_ff;
   logic [CW-1:0] aux_cnt_ff;
   logic fail_ff;
   wire logic p_tick = p_sync_ff[1] & ~p_last_ff;
   wire logic a_tick = a_sync_ff[1] & ~a_last_ff;
   // stop of either oscillator caught after T1 of system clock
   wire logic p_lost = scsup_hit(p_idle_ff, CW'(T1_CYC));
   wire logic a_lost = scsup_hit(a_idle_ff, CW'(T1_CYC));
   // window closes on primary ticks, so primary drift stretches or shrinks it
   wire logic win_end = p_tick & scsup_hit(win_ff, CW'(WIN_TICKS));
   wire logic [CW-1:0] aux_now = aux_cnt_ff + {23'h00_0000, a_tick};
   wire logic mismatch = win_end & (aux_now < CW'(WIN_LO) | aux_now > CW'(WIN_HI));
   wire logic nxt_fail = mif.enable & (p_lost | a_lost | mismatch);
   wire logic [CW-1:0] nxt_p_idle = (!mif.enable | p_tick) ? '0 : scsup_inc(p_idle_ff);
   wire logic [CW-1:0] nxt_a_idle = (!mif.enable | a_tick) ? '0 : scsup_inc(a_idle_ff);
   wire logic [CW-1:0] nxt_win = (!mif.enable | win_end) ? '0 : win_ff + {23'h00_0000, p_tick};
   wire logic [CW-1:0] nxt_aux_cnt = (!mif.enable | win_end) ? '0 : aux_now;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         p_sync_ff <= 2'h0;
         a_sync_ff <= 2'h0;
         p_last_ff <= 1'b0;
         a_last_ff <= 1'b0;
         p_idle_ff <= '0;
         a_idle_ff <= '0;
         win_ff <= '0;
         aux_cnt_ff <= '0;
         fail_ff <= 1'b0;
      end
      else
      begin
         p_sync_ff <= {p_sync_ff[0], mif.prim_pin};
         a_sync_ff <= {a_sync_ff[0], mif.aux_pin};
         p_last_ff <= p_sync_ff[1];
         a_last_ff <= a_sync_ff[1];
         p_idle_ff <= nxt_p_idle;
         a_idle_ff <= nxt_a_idle;
         win_ff <= nxt_win;
         aux_cnt_ff <= nxt_aux_cnt;
         fail_ff <= nxt_fail;
      end
   end
   assign mif.fail = fail_ff;
   mon_gated_a: assert property (@(posedge clock) disable iff (!rstn)
      !mif.enable |=> !mif.fail) else $error("monitor fail while disabled");
   lost_fail_a: assert property (@(posedge clock) disable iff (!rstn)
      (mif.enable && p_lost) |=> mif.fail) else $error("lost oscillator not flagged");
endmodule
`default_nettype wire

// file: core/scsup_mon_if.sv
`timescale 1ns/100ps
`default_nettype none
interface scsup_mon_if;
   logic enable;
   logic prim_pin;
   logic aux_pin;
   logic fail;
   modport mon (input enable, input prim_pin, input aux_pin, output fail);
   modport ctl (output enable, output prim_pin, output aux_pin, input fail);
endinterface
`default_nettype wire

// file: core/scsup_pkg.sv
// Overview of operation
// - with reset line high and no fault, drivers and serial state run normally.
// - internal rail low drives reset, drivers off, state cleared, rail flag set.
// - clock failure drives reset, drivers off, rail flag kept, clock flag set.
// - io, 5 V or external reset: drivers off, state cleared, cause flags kept.
// - battery fault: valves off, setpoints and pump register cleared, reset untouched.
// - reset outputs hold for the fault and the recovery period after it.
// - recovery starts only when internal rail, io and 5 V supplies are all back to normal; a battery fault does not hold it.
// - internal rail filter on both edges, flag set once the filter passes, then recovery.
// - io supply filter on both edges, flag set, then recovery.
// - clock supervision runs only while the reset line is high.
// - stopped or mismatched oscillator produces reset and clock flag.
// - every reset flag clears when a read returns it.
// - monitoring stays off until the clock flag has been cleared.
// - missing oscillator reported between short unit and twice long unit.
// - mismatch measured over long-unit window counted on primary oscillator.
// - aux disable stops aux oscillator and supervision only.
// - spread spectrum enable modulates oscillator, select picks deviation.
// - temperature warning is live status and shuts nothing off.
// - both gate-rail voltages readable in messages six and seven.
// - external reset lows shorter than the filter time are ignored.
// - internal rail filter time is one millisecond, both directions.
package scsup_pkg;
   localparam int CLK_MHZ = 50;
   localparam int T1_US = 10;
   localparam int T2_US = 100;
   localparam int T1_CYC = T1_US * CLK_MHZ;
   localparam int VINT_FILT_US = 1000;
   localparam int VINT_FILT_CYC = VINT_FILT_US * CLK_MHZ;
   localparam int REC_MS = 45;
   localparam int REC_CYC = REC_MS * 1000 * CLK_MHZ;
   localparam int EXT_FILT_NS = 2000;
   localparam int EXT_FILT_CYC = (EXT_FILT_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_NOM_MHZ = 14;
   localparam int OSC_TOL_PCT = 25;
   localparam int WIN_TICKS = T2_US * OSC_NOM_MHZ;
   localparam int WIN_LO = WIN_TICKS * (100 - OSC_TOL_PCT) / 100;
   localparam int WIN_HI = WIN_TICKS * (100 + OSC_TOL_PCT) / 100;
   localparam int CW = 24;
   localparam logic [3:0] MSG_GATE_LOW = 4'h6;
   localparam logic [3:0] MSG_GATE_HIGH = 4'h7;
   localparam logic [9:0] FM_DEV_LO_KHZ = 10'h15E;
   localparam logic [9:0] FM_DEV_HI_KHZ = 10'h2BC;
   localparam int CH_VINT = 0;
   localparam int CH_IO = 1;
   localparam int CH_5V = 2;
   localparam int CH_EXT = 3;
   localparam int NCH = 4;
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_HOLD = 3'b010,
      ST_RECOVER = 3'b100
   } scsup_state_type;
   function automatic logic scsup_hit(input logic [CW-1:0] c, input logic [CW-1:0] lim);
      return c >= lim - 24'h00_0001;
   endfunction
   function automatic logic [CW-1:0] scsup_inc(input logic [CW-1:0] c);
      return (c == {CW{1'b1}}) ? c : c + 24'h00_0001;
   endfunction
endpackage

// file: core/scsup_top.sv
`timescale 1ns/100ps
`default_nettype none
module scsup_top
   import scsup_pkg::*;
#(
   parameter logic [CW-1:0] VINT_FILT_CYCLES = CW'(VINT_FILT_CYC),
   parameter logic [CW-1:0] REC_CYCLES = CW'(REC_CYC)
)
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic vint_a_low,
   input wire logic vint_d_low,
   input wire logic io_supply_low,
   input wire logic five_volt_low,
   input wire logic battery_over,
   input wire logic battery_under,
   input wire logic temp_warn_raw,
   input wire logic system_reset_line_in,
   output logic system_reset_line_out,
   output logic system_reset_line_oe,
   input wire logic primary_oscillator,
   input wire logic auxiliary_oscillator,
   input wire logic flag_read,
   input wire logic aux_osc_disable,
   input wire logic spread_spectrum_enable,
   input wire logic spread_deviation_select,
   input wire logic rail_read,
   input wire logic [3:0] rail_msg,
   input wire logic [9:0] gate_rail_low,
   input wire logic [9:0] gate_rail_high,
   output logic [9:0] rail_data,
   output logic valve_drivers_off,
   output logic pump_drive_control_off,
   output logic resistive_load_driver_off,
   output logic spi_state_clear,
   output logic valve_setpoint_clear,
   output logic pump_reg_clear,
   output logic normal_run,
   output logic internal_supply_low_flag,
   output logic five_volt_low_flag,
   output logic io_supply_low_flag,
   output logic ext_reset_flag,
   output logic clock_fail_flag,
   output logic temp_warn,
   output logic aux_osc_run,
   output logic spread_enable_out,
   output logic [9:0] spread_dev_khz
);
   // pins from the analogue side or outside world, two stages each
   localparam int NS = 8;
   logic [NS-1:0] sync1_ff;
   logic [NS-1:0] sync2_ff;
   wire logic [NS-1:0] pins = {temp_warn_raw, system_reset_line_in, battery_under,
      battery_over, five_volt_low, io_supply_low, vint_d_low, vint_a_low};
   wire logic s_vint = sync2_ff[0] | sync2_ff[1];
   wire logic s_io = sync2_ff[2];
   wire logic s_5v = sync2_ff[3];
   wire logic s_batt = sync2_ff[4] | sync2_ff[5];
   wire logic s_line = sync2_ff[6];
   wire logic s_temp = sync2_ff[7];
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end
      else
      begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
      end
   end

   // own drive echoes back through pin and synchroniser for a few cycles
   logic [2:0] oe_hist_ff;
   wire logic own_drive = system_reset_line_oe | (|oe_hist_ff);
   wire logic ext_low = ~s_line & ~own_drive;

   // fault filters, symmetric except the external reset
   logic [CW-1:0] cnt_ff [NCH];
   logic [NCH-1:0] filt_ff;
   wire logic [NCH-1:0] raw = {ext_low, s_5v, s_io, s_vint};
   wire logic [CW-1:0] lim [NCH];
   assign lim[CH_VINT] = VINT_FILT_CYCLES;
   assign lim[CH_IO] = CW'(T1_CYC);
   assign lim[CH_5V] = CW'(T1_CYC);
   assign lim[CH_EXT] = CW'(EXT_FILT_CYC);
   logic [CW-1:0] nxt_cnt [NCH];
   logic [NCH-1:0] nxt_filt;
   for (genvar i = 0; i < NCH; i++)
   begin : g_filt
      // counter restarts whenever raw agrees with the filtered level
      wire logic differ = raw[i] ^ filt_ff[i];
      wire logic fast_rel = (i == CH_EXT) && !raw[i];
      wire logic done = differ & scsup_hit(cnt_ff[i], lim[i]);
      assign nxt_cnt[i] = (differ & ~done & ~fast_rel) ? scsup_inc(cnt_ff[i]) : '0;
      assign nxt_filt[i] = fast_rel ? 1'b0 : (done ? raw[i] : filt_ff[i]);
      always_ff @(posedge clock or negedge rstn)
      begin
         if (!rstn)
         begin
            cnt_ff[i] <= '0;
            filt_ff[i] <= 1'b0;
         end
         else
         begin
            cnt_ff[i] <= nxt_cnt[i];
            filt_ff[i] <= nxt_filt[i];
         end
      end
   end

   wire logic f_vint = filt_ff[CH_VINT];
   wire logic f_ext = filt_ff[CH_EXT];
   wire logic supply_low = filt_ff[CH_VINT] | filt_ff[CH_IO] | filt_ff[CH_5V];

   // clock monitor
   scsup_mon_if mif ();
   logic aux_off_ff;
   assign mif.prim_pin = primary_oscillator;
   assign mif.aux_pin = auxiliary_oscillator;
   assign mif.enable = s_line & ~own_drive & ~aux_off_ff & ~clock_fail_flag;
   wire logic clk_evt = mif.fail;
   scsup_clkmon u_clkmon (
      .clock(clock),
      .rstn(rstn),
      .mif(mif)
   );

   // reset sequencer; power-up passes through recovery too
   scsup_state_type state_ff;
   scsup_state_type nxt_state;
   logic [CW-1:0] rec_ff;
   wire logic in_reset = state_ff != ST_RUN;
   wire logic rec_done = scsup_hit(rec_ff, REC_CYCLES);
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ST_RUN:
            if (supply_low | clk_evt)
               nxt_state = ST_HOLD;
         ST_HOLD:
            if (!supply_low)
               nxt_state = ST_RECOVER;
         ST_RECOVER:
            if (supply_low | clk_evt)
               nxt_state = ST_HOLD;
            else if (rec_done)
               nxt_state = ST_RUN;
         default:
            nxt_state = ST_HOLD;
      endcase
   end
   wire logic [CW-1:0] nxt_rec = (state_ff == ST_RECOVER && nxt_state == ST_RECOVER)
      ? scsup_inc(rec_ff) : '0;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         state_ff <= ST_HOLD;
         rec_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         rec_ff <= nxt_rec;
      end
   end

   // reset-cause flags; a set in the read cycle beats the clear
   logic vint_flag_ff;
   logic v5_flag_ff;
   logic io_flag_ff;
   logic ext_flag_ff;
   logic clk_flag_ff;
   wire logic keep_v5 = v5_flag_ff & ~flag_read;
   wire logic keep_io = io_flag_ff & ~flag_read;
   wire logic keep_ext = ext_flag_ff & ~flag_read;
   wire logic nxt_vint_flag = f_vint | (vint_flag_ff & ~flag_read);
   wire logic nxt_v5_flag = ~f_vint & ~clk_evt & (filt_ff[CH_5V] | keep_v5);
   wire logic nxt_io_flag = ~f_vint & ~clk_evt & (filt_ff[CH_IO] | keep_io);
   wire logic nxt_ext_flag = ~f_vint & ~clk_evt & (f_ext | keep_ext);
   wire logic nxt_clk_flag = ~f_vint & (clk_evt | (clk_flag_ff & ~flag_read));
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         vint_flag_ff <= 1'b0;
         v5_flag_ff <= 1'b0;
         io_flag_ff <= 1'b0;
         ext_flag_ff <= 1'b0;
         clk_flag_ff <= 1'b0;
      end
      else
      begin
         vint_flag_ff <= nxt_vint_flag;
         v5_flag_ff <= nxt_v5_flag;
         io_flag_ff <= nxt_io_flag;
         ext_flag_ff <= nxt_ext_flag;
         clk_flag_ff <= nxt_clk_flag;
      end
   end
   assign internal_supply_low_flag = vint_flag_ff;
   assign five_volt_low_flag = v5_flag_ff;
   assign io_supply_low_flag = io_flag_ff;
   assign ext_reset_flag = ext_flag_ff;
   assign clock_fail_flag = clk_flag_ff;

   // output stage; battery faults leave reset and load driver alone
   wire logic all_off = in_reset | f_ext;
   wire logic nxt_valve_off = all_off | s_batt;
   wire logic nxt_normal = ~all_off & ~s_batt;
   wire logic [9:0] nxt_rail = (rail_msg == MSG_GATE_LOW) ? gate_rail_low
      : (rail_msg == MSG_GATE_HIGH) ? gate_rail_high : 10'h000;
   wire logic [9:0] nxt_dev = spread_deviation_select ? FM_DEV_HI_KHZ : FM_DEV_LO_KHZ;
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         system_reset_line_out <= 1'b0;
         system_reset_line_oe <= 1'b1;
         oe_hist_ff <= 3'h7;
         valve_drivers_off <= 1'b1;
         pump_drive_control_off <= 1'b1;
         resistive_load_driver_off <= 1'b1;
         spi_state_clear <= 1'b1;
         valve_setpoint_clear <= 1'b1;
         pump_reg_clear <= 1'b1;
         normal_run <= 1'b0;
         temp_warn <= 1'b0;
         aux_off_ff <= 1'b0;
         aux_osc_run <= 1'b1;
         spread_enable_out <= 1'b0;
         spread_dev_khz <= FM_DEV_LO_KHZ;
         rail_data <= 10'h000;
      end
      else
      begin
         system_reset_line_out <= ~in_reset;
         system_reset_line_oe <= in_reset;
         oe_hist_ff <= {oe_hist_ff[1:0], system_reset_line_oe};
         valve_drivers_off <= nxt_valve_off;
         pump_drive_control_off <= all_off;
         resistive_load_driver_off <= all_off;
         spi_state_clear <= all_off;
         valve_setpoint_clear <= nxt_valve_off;
         pump_reg_clear <= nxt_valve_off;
         normal_run <= nxt_normal;
         temp_warn <= s_temp;
         aux_off_ff <= aux_osc_disable;
         aux_osc_run <= ~aux_osc_disable;
         spread_enable_out <= spread_spectrum_enable;
         spread_dev_khz <= nxt_dev;
         if (rail_read)
            rail_data <= nxt_rail;
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   reset_hold_a: assert property (in_reset |=> system_reset_line_oe)
      else $error("reset line not driven in reset state");
   vint_flag_a: assert property (f_vint |=> internal_supply_low_flag && in_reset)
      else $error("rail low did not set flag");
   clk_flag_a: assert property (clk_evt && !f_vint |=> clock_fail_flag && in_reset)
      else $error("clock failure not latched");
   flag_clear_a: assert property (flag_read && !clk_evt |=> !clock_fail_flag)
      else $error("clock flag survived read");
   batt_only_a: assert property (s_batt && !all_off |=> valve_drivers_off
      && valve_setpoint_clear && !resistive_load_driver_off && !system_reset_line_oe)
      else $error("battery fault reaction wrong");
   mon_hold_a: assert property (clock_fail_flag |=> !clk_evt)
      else $error("monitor ran with clock flag set");
   recover_a: assert property ($rose(state_ff == ST_RECOVER) |-> !$past(supply_low))
      else $error("recovery began with supply low");
   ext_glitch_a: assert property ($rose(f_ext) |-> $past(ext_low, 1)
      && $past(cnt_ff[CH_EXT]) == CW'(EXT_FILT_CYC) - 24'h00_0001)
      else $error("short external low passed the filter");
   temp_live_a: assert property (s_temp && nxt_normal |=> temp_warn && normal_run)
      else $error("temperature warning affected outputs");
   rail_read_a: assert property (rail_read && rail_msg == MSG_GATE_HIGH
      |=> rail_data == $past(gate_rail_high)) else $error("gate rail readback wrong");
   run_exit_c: cover property (state_ff == ST_RECOVER ##1 state_ff == ST_RUN);
   clk_fail_c: cover property (clk_evt);
   ext_reset_c: cover property ($rose(f_ext));
   batt_fault_c: cover property (s_batt && state_ff == ST_RUN);
endmodule
`default_nettype wire

// file: test/scsup_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the open-drain reset wire; the line has a pull-up
module scsup_host_model
(
   input wire logic clock,
   input wire logic device_pull,
   input wire logic go,
   input wire logic [15:0] len,
   output logic line_level
);
   logic [15:0] low_cnt_ff = 16'h0000;
   always @(posedge clock)
   begin
      if (go)
         low_cnt_ff <= len;
      else if (low_cnt_ff != 16'h0000)
         low_cnt_ff <= low_cnt_ff - 16'h0001;
   end
   // released by both parties reads high, never a stale value
   assign line_level = ~(device_pull | (low_cnt_ff != 16'h0000));
endmodule
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import scsup_pkg::*;
;
   logic clock, rstn, vint_a_low, vint_d_low, io_supply_low, five_volt_low;
   logic battery_over, battery_under, temp_warn_raw, flag_read, aux_osc_disable;
   logic spread_spectrum_enable, spread_deviation_select, rail_read;
   logic primary_oscillator, auxiliary_oscillator, host_go, pc;
   logic [3:0] rail_msg, aux_half, ac;
   logic [9:0] gate_rail_low, gate_rail_high, rail_data, spread_dev_khz;
   logic [15:0] host_len;
   logic system_reset_line_in, system_reset_line_out, system_reset_line_oe;
   logic valve_drivers_off, pump_drive_control_off, resistive_load_driver_off;
   logic spi_state_clear, valve_setpoint_clear, pump_reg_clear, normal_run;
   logic internal_supply_low_flag, five_volt_low_flag, io_supply_low_flag;
   logic ext_reset_flag, clock_fail_flag, temp_warn, aux_osc_run, spread_enable_out;
   int num_errors, checks, cyc;
   // small counts keep the run short
   scsup_top #(.VINT_FILT_CYCLES(24'h00_0014), .REC_CYCLES(24'h00_001E)) u_scsup_top (.*);
   scsup_host_model u_scsup_host_model (.clock(clock), .device_pull(system_reset_line_oe),
      .go(host_go), .len(host_len), .line_level(system_reset_line_in));
   initial
   begin
      clock = 0;
      forever #10 clock = ~clock;
   end
   // oscillators stepped on the clock: primary period 4 cycles, aux by aux_half
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      pc <= ~pc;
      if (pc)
         primary_oscillator <= ~primary_oscillator;
      if (aux_half != 4'h0)
      begin
         ac <= (ac >= aux_half - 4'h1) ? 4'h0 : ac + 4'h1;
         if (ac >= aux_half - 4'h1)
            auxiliary_oscillator <= ~auxiliary_oscillator;
      end
      if (cyc == 90000)
      begin
         num_errors++;
         report_and_stop();
      end
   end
   task report_and_stop;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic g, input logic e, input string m);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task chkw(input logic [9:0] g, input logic [9:0] e, input string m);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task cyc_n(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task wait_oe(input logic e, input int lim);
      int n;
      n = 0;
      #1;
      while (system_reset_line_oe !== e && n < lim)
      begin
         @(posedge clock);
         #1;
         n++;
      end
      chk(system_reset_line_oe, e, "reset drive");
      chk(system_reset_line_out, ~e, "reset level");
   endtask
   task read_flags;
      @(posedge clock) flag_read <= 1;
      @(posedge clock) flag_read <= 0;
      #1;
   endtask
   task flags(input logic [4:0] e);
      chkw({5'h00, internal_supply_low_flag, five_volt_low_flag, io_supply_low_flag,
         ext_reset_flag, clock_fail_flag}, {5'h00, e}, "flags");
   endtask
   task off3(input logic e);
      chkw({spi_state_clear, valve_drivers_off, pump_drive_control_off,
         resistive_load_driver_off}, {6'h00, {4{e}}}, "drivers");
   endtask
   task host_pull(input logic [15:0] n);
      @(posedge clock) host_len <= n;
      host_go <= 1;
      @(posedge clock) host_go <= 0;
   endtask
   initial
   begin
      {vint_a_low, vint_d_low, io_supply_low, five_volt_low, battery_over} = 0;
      {battery_under, temp_warn_raw, flag_read, aux_osc_disable, rail_read} = 0;
      {spread_spectrum_enable, spread_deviation_select, host_go, pc} = 0;
      {primary_oscillator, auxiliary_oscillator, num_errors, checks, cyc} = 0;
      rail_msg = 4'h0;
      aux_half = 4'h2;
      ac = 4'h0;
      host_len = 16'h0000;
      gate_rail_low = 10'h155;
      gate_rail_high = 10'h2AA;
      rstn = 0;
      repeat (5) @(posedge clock);
      rstn <= 1;
      wait_oe(0, 200);
      chk(normal_run, 1, "run");
      off3(0);
      read_flags();
      flags(5'h00);
      @(posedge clock) vint_a_low <= 1;
      cyc_n(10);
      @(posedge clock) vint_a_low <= 0;
      cyc_n(40);
      chk(system_reset_line_oe, 0, "short dip");
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clock) {vint_a_low, vint_d_low} <= i ? 2'h1 : 2'h2;
         wait_oe(1, 40);
         off3(1);
         chk(internal_supply_low_flag, 1, "rail flag");
         @(posedge clock) {vint_a_low, vint_d_low} <= 2'h0;
         wait_oe(0, 100);
         chk(internal_supply_low_flag, 1, "rail flag kept");
         read_flags();
         flags(5'h00);
      end
      @(posedge clock) {io_supply_low, five_volt_low} <= 2'h3;
      wait_oe(1, 520);
      chk(io_supply_low_flag & five_volt_low_flag, 1, "supply flags");
      off3(1);
      @(posedge clock) io_supply_low <= 0;
      cyc_n(600);
      chk(system_reset_line_oe, 1, "held");
      @(posedge clock) five_volt_low <= 0;
      wait_oe(0, 600);
      read_flags();
      flags(5'h00);
      host_pull(16'h0032);
      cyc_n(150);
      chk(valve_drivers_off, 0, "glitch");
      flags(5'h00);
      host_pull(16'h012C);
      cyc_n(150);
      off3(1);
      chk(ext_reset_flag, 1, "ext flag");
      chk(system_reset_line_oe, 0, "ext no drive");
      cyc_n(250);
      chk(normal_run, 1, "ext end");
      read_flags();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clock) {battery_over, battery_under} <= i ? 2'h1 : 2'h2;
         cyc_n(5);
         chkw({system_reset_line_oe, valve_drivers_off, valve_setpoint_clear,
            pump_reg_clear, pump_drive_control_off, resistive_load_driver_off},
            10'h01C, "battery");
         @(posedge clock) {battery_over, battery_under} <= 2'h0;
         cyc_n(5);
         chk(valve_drivers_off, 0, "battery end");
      end
      @(posedge clock) temp_warn_raw <= 1;
      cyc_n(5);
      chkw({temp_warn, valve_drivers_off}, 10'h002, "temp on");
      @(posedge clock) temp_warn_raw <= 0;
      cyc_n(5);
      chk(temp_warn, 0, "temp off");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clock) {spread_spectrum_enable, spread_deviation_select} <= 2'(i);
         cyc_n(5);
         chkw(spread_dev_khz, i[0] ? FM_DEV_HI_KHZ : FM_DEV_LO_KHZ, "deviation");
         chk(spread_enable_out, i[1], "spread");
      end
      for (int m = 5; m < 8; m++)
      begin
         @(posedge clock) rail_msg <= 4'(m);
         rail_read <= 1;
         @(posedge clock) rail_read <= 0;
         #1;
         chkw(rail_data, m == 6 ? gate_rail_low : m == 7 ? gate_rail_high : 10'h000,
            "rail data");
      end
      @(posedge clock) aux_osc_disable <= 1;
      aux_half <= 4'h0;
      cyc_n(5);
      chk(aux_osc_run, 0, "aux off");
      cyc_n(12000);
      chkw({system_reset_line_oe, normal_run}, 10'h001, "no monitor");
      @(posedge clock) aux_osc_disable <= 0;
      aux_half <= 4'h2;
      cyc_n(12000);
      read_flags();
      @(posedge clock) aux_half <= 4'h0;
      cyc_n(400);
      chk(system_reset_line_oe, 0, "too early");
      wait_oe(1, 10600);
      chk(clock_fail_flag, 1, "clock flag");
      off3(1);
      wait_oe(0, 100);
      cyc_n(12000);
      chk(system_reset_line_oe, 0, "monitor off");
      @(posedge clock) aux_half <= 4'h2;
      read_flags();
      flags(5'h00);
      cyc_n(12000);
      chk(system_reset_line_oe, 0, "clocks fine");
      @(posedge clock) aux_half <= 4'h3;
      wait_oe(1, 12000);
      chk(clock_fail_flag, 1, "mismatch flag");
      @(posedge clock) aux_half <= 4'h2;
      wait_oe(0, 100);
      @(posedge clock) rstn <= 0;
      cyc_n(2);
      off3(1);
      flags(5'h00);
      @(posedge clock) rstn <= 1;
      wait_oe(0, 200);
      chk(normal_run, 1, "run again");
      report_and_stop();
   end
endmodule
`default_nettype wire
